// File: design/fesc_pkg.sv
/*
  Package for the flash erase/setup control block: register addresses,
  field positions, reset values, block map and timing constants.
  Assumes a 16-bit CPU address bus and byte-wide register data.
*/
package fesc_pkg;
  localparam logic [15:0] ADDR_PRIMARY     = 16'hff80;
  localparam logic [15:0] ADDR_SETUP_ERROR = 16'hff81;
  localparam logic [15:0] ADDR_BLOCK_SEL   = 16'hff83;
  localparam logic [15:0] ADDR_MODE_MON    = 16'hff89;
  localparam logic [15:0] ADDR_MAP_CTRL    = 16'hff8f;
  localparam logic [15:0] ADDR_FLASH_LO    = 16'hff80;
  localparam logic [15:0] ADDR_FLASH_HI    = 16'hff83;

  // Primary control fields
  localparam int PRI_WP_LEVEL  = 7;
  localparam int PRI_SW_PERMIT = 6;
  localparam int PRI_ERASE_VFY = 3;
  localparam int PRI_PROG_VFY  = 2;
  localparam int PRI_ERASE_GO  = 1;
  localparam int PRI_PROG_GO   = 0;

  // Setup and error fields
  localparam int SE_ERROR_FLAG  = 7;
  localparam int SE_ERASE_SETUP = 1;
  localparam int SE_PROG_SETUP  = 0;

  localparam int MAP_REG_ENABLE = 3;
  localparam int NUM_BLOCKS     = 7;

  localparam logic [7:0] RESET_VALUE_ZERO = 8'h00;

  // Erase block map: start addresses, block 6 ends below 16'hee00
  localparam logic [15:0] BLOCK_START [NUM_BLOCKS] = '{16'h0000, 16'h0400, 16'h0800, 16'h0c00,
                                                      16'h1000, 16'h8000, 16'hc000};
  localparam logic [15:0] BLOCK_END   [NUM_BLOCKS] = '{16'h03ff, 16'h07ff, 16'h0bff, 16'h0fff,
                                                      16'h7fff, 16'hbfff, 16'hedff};

  // Each register access takes two states
  localparam int ACCESS_STATES = 2;
endpackage : fesc_pkg

// File: design/fesc_sync.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes the input is asynchronous to core_clk; output changes once
  stages two and three agree.
*/
`timescale 1ns/1ps
module fesc_sync #(
  parameter logic INIT = 1'b0
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      sync_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // Shift chain; the first stage feeds only the second
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Filtered level holds until the two late stages agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_out <= INIT;
    end else if (s2_reg == s3_reg) begin
      sync_out <= s3_reg;
    end
  end
endmodule : fesc_sync

// File: design/fesc_top.sv
/*
  Flash program/erase setup and error control: primary control, setup and
  error, erase block select, mode pin monitor and register map control.
  Assumes a byte-wide CPU bus with one-cycle request strobes, board-driven
  mode and write-protect pins, and a flash core reporting errors as pulses.
*/
`timescale 1ns/1ps
// Summary of operation
// R1: Reset clears setup-and-error register.
// R2: Standby and protect modes clear setup bits.
// R3: Error flag sets on error, reset-only clear.
// R4: Reserved setup bits read zero, ignore writes.
// R5: Erase setup needs pin high, permit set.
// R6: Program setup needs pin high, permit set.
// R7: Software sets one sequencing bit per write.
// R8: Block select clears on reset/standby/no-permit.
// R9: Seven block-select bits gate block erase.
// R10: Software selects at most one block.
// R11: Fixed seven-block address map.
// R12: Mode monitor shows pins, upper on bit1.
// R13: Map control resets zero, bit 3 writable.
// R14: Enable bit maps flash registers FF80-FF83.
// R15: Boot/user mode chosen from pins at release.
// R16: Board holds write-protect low normally.
// R17: Registers at FF80, FF81, FF83.
// R18: Go bits need matching setup bit.
// R19: Byte-only accesses, two states each.
// R20: Unmapped writes leave registers unchanged.
module fesc_top (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        bus_req,
  input  wire logic        bus_wr,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  output logic [7:0]       bus_rdata,
  output logic             bus_ack,
  output logic             bus_sel,
  input  wire logic        write_protect_pin,
  input  wire logic        upper_mode_pin,
  input  wire logic        lower_mode_pin,
  input  wire logic        standby,
  input  wire logic        flash_error,
  input  wire logic [15:0] erase_addr,
  output logic             erase_allowed,
  output logic             error_protect,
  output logic             boot_mode,
  output logic             user_program_mode,
  output logic             erase_active,
  output logic             program_active,
  output logic             erase_verify,
  output logic             program_verify
);
  logic       wp_level;
  logic       upper_level;
  logic       lower_level;
  logic       sw_permit_reg;
  logic       erase_go_reg;
  logic       prog_go_reg;
  logic       erase_vfy_reg;
  logic       prog_vfy_reg;
  logic       error_flag_reg;
  logic       erase_setup_reg;
  logic       prog_setup_reg;
  logic [6:0] block_sel_reg;
  logic       map_enable_reg;
  logic       busy_reg;
  logic       pend_wr_reg;
  logic [15:0] pend_addr_reg;
  logic [7:0] pend_data_reg;
  logic       mode_taken_reg;
  logic [2:0] settle_reg;
  logic       u_sync_done;
  logic       permit;
  logic       protect;
  logic       wr_fire;
  logic       in_flash_space;
  logic [7:0] rd_next;
  logic       erase_hit;

  fesc_sync #(.INIT(1'b0)) u_sync_wp (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (write_protect_pin),
    .sync_out (wp_level)
  );
  fesc_sync #(.INIT(1'b0)) u_sync_upper (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (upper_mode_pin),
    .sync_out (upper_level)
  );
  fesc_sync #(.INIT(1'b0)) u_sync_lower (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (lower_mode_pin),
    .sync_out (lower_level)
  );

  // Protection qualifiers: permit gates setup and go bits, protect clears setup bits
  assign permit  = wp_level & sw_permit_reg;
  assign protect = standby | ~wp_level | ~sw_permit_reg | error_flag_reg;
  assign in_flash_space = (pend_addr_reg >= fesc_pkg::ADDR_FLASH_LO) &&
                          (pend_addr_reg <= fesc_pkg::ADDR_FLASH_HI);
  assign wr_fire = busy_reg & pend_wr_reg;

  // Two-state access: capture on request, act and ack one cycle later
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_reg      <= 1'b0;
      pend_wr_reg   <= 1'b0;
      pend_addr_reg <= 16'h0000;
      pend_data_reg <= 8'h00;
    end else if (!busy_reg && bus_req) begin
      busy_reg      <= 1'b1; // see R19
      pend_wr_reg   <= bus_wr;
      pend_addr_reg <= bus_addr;
      pend_data_reg <= bus_wdata;
    end else begin
      busy_reg      <= 1'b0;
      pend_wr_reg   <= 1'b0;
    end
  end

  // Map control: only the enable bit is stored
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      map_enable_reg <= 1'b0; // see R13
    end else if (wr_fire && pend_addr_reg == fesc_pkg::ADDR_MAP_CTRL) begin
      map_enable_reg <= pend_data_reg[fesc_pkg::MAP_REG_ENABLE]; // see R13
    end
  end

  // Primary control; permit bit needs the pin, the rest need the permit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sw_permit_reg <= 1'b0;
      erase_vfy_reg <= 1'b0;
      prog_vfy_reg  <= 1'b0;
      erase_go_reg  <= 1'b0;
      prog_go_reg   <= 1'b0;
    end else if (standby || !wp_level) begin
      sw_permit_reg <= 1'b0;
      erase_vfy_reg <= 1'b0;
      prog_vfy_reg  <= 1'b0;
      erase_go_reg  <= 1'b0;
      prog_go_reg   <= 1'b0;
    end else if (wr_fire && map_enable_reg && pend_addr_reg == fesc_pkg::ADDR_PRIMARY) begin // see R14, R20
      sw_permit_reg <= pend_data_reg[fesc_pkg::PRI_SW_PERMIT];
      erase_vfy_reg <= pend_data_reg[fesc_pkg::PRI_ERASE_VFY] & sw_permit_reg;
      prog_vfy_reg  <= pend_data_reg[fesc_pkg::PRI_PROG_VFY] & sw_permit_reg;
      erase_go_reg  <= pend_data_reg[fesc_pkg::PRI_ERASE_GO] & permit & erase_setup_reg
                       & ~error_flag_reg; // see R18
      prog_go_reg   <= pend_data_reg[fesc_pkg::PRI_PROG_GO] & permit & prog_setup_reg
                       & ~error_flag_reg; // see R18
    end else if (error_flag_reg) begin
      erase_go_reg  <= 1'b0; // see R3
      prog_go_reg   <= 1'b0;
    end
  end

  // Error flag: set by the flash core, only reset clears it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      error_flag_reg <= 1'b0; // see R1, R3
    end else if (flash_error) begin
      error_flag_reg <= 1'b1; // see R3
    end
  end

  // Setup bits; writes to reserved bits 6..2 are dropped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      erase_setup_reg <= 1'b0; // see R1
      prog_setup_reg  <= 1'b0;
    end else if (protect) begin
      erase_setup_reg <= 1'b0; // see R2, R3
      prog_setup_reg  <= 1'b0;
    end else if (wr_fire && map_enable_reg && pend_addr_reg == fesc_pkg::ADDR_SETUP_ERROR) begin // see R4, R20
      erase_setup_reg <= pend_data_reg[fesc_pkg::SE_ERASE_SETUP] & permit; // see R5
      prog_setup_reg  <= pend_data_reg[fesc_pkg::SE_PROG_SETUP] & permit; // see R6
    end
  end

  // Block select: cleared whenever programming is not permitted
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      block_sel_reg <= 7'h00; // see R8
    end else if (standby || !permit) begin
      block_sel_reg <= 7'h00; // see R8
    end else if (wr_fire && map_enable_reg && pend_addr_reg == fesc_pkg::ADDR_BLOCK_SEL) begin // see R20
      block_sel_reg <= pend_data_reg[6:0]; // see R9
    end
  end

  // Address decode against the block map; hazard of multiple selects left to software
  always_comb begin
    erase_hit = 1'b0;
    for (int i = 0; i < fesc_pkg::NUM_BLOCKS; i++) begin
      if (block_sel_reg[i] && erase_addr >= fesc_pkg::BLOCK_START[i] &&
          erase_addr <= fesc_pkg::BLOCK_END[i]) begin
        erase_hit = 1'b1; // see R9, R11
      end
    end
  end

  // Read mux; unmapped flash window and unknown addresses read zero
  always_comb begin
    rd_next = fesc_pkg::RESET_VALUE_ZERO;
    if (pend_addr_reg == fesc_pkg::ADDR_MODE_MON) begin
      rd_next = {6'h00, upper_level, lower_level}; // see R12
    end else if (pend_addr_reg == fesc_pkg::ADDR_MAP_CTRL) begin
      rd_next = {4'h0, map_enable_reg, 3'h0}; // see R13
    end else if (map_enable_reg && pend_addr_reg == fesc_pkg::ADDR_PRIMARY) begin // see R14, R17
      rd_next = {wp_level, sw_permit_reg, 2'b00, erase_vfy_reg, prog_vfy_reg, erase_go_reg, prog_go_reg};
    end else if (map_enable_reg && pend_addr_reg == fesc_pkg::ADDR_SETUP_ERROR) begin // see R17
      rd_next = {error_flag_reg, 5'h00, erase_setup_reg, prog_setup_reg}; // see R4
    end else if (map_enable_reg && pend_addr_reg == fesc_pkg::ADDR_BLOCK_SEL) begin // see R17
      rd_next = {1'b0, block_sel_reg};
    end
  end

  // Bus answer registered so outputs come from flops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_rdata <= 8'h00;
      bus_ack   <= 1'b0;
      bus_sel   <= 1'b0;
    end else begin
      bus_ack   <= busy_reg;
      bus_rdata <= (busy_reg && !pend_wr_reg) ? rd_next : 8'h00;
      bus_sel   <= busy_reg & map_enable_reg & in_flash_space; // see R14
    end
  end

  // Mode latched once, first cycle after pins have synchronised past release
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_taken_reg    <= 1'b0;
      boot_mode         <= 1'b0;
      user_program_mode <= 1'b0;
    end else if (!mode_taken_reg && u_sync_done) begin
      mode_taken_reg    <= 1'b1;
      boot_mode         <= wp_level & ~upper_level & ~lower_level; // see R15
      user_program_mode <= wp_level & upper_level & ~lower_level; // see R15
    end
  end

  // Settling counter: pins need four cycles through the synchronisers
  assign u_sync_done = (settle_reg == 3'h4);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      settle_reg <= 3'h0;
    end else if (!u_sync_done) begin
      settle_reg <= settle_reg + 3'h1;
    end
  end

  // Status outputs for the flash core
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      erase_allowed  <= 1'b0;
      error_protect  <= 1'b0;
      erase_active   <= 1'b0;
      program_active <= 1'b0;
      erase_verify   <= 1'b0;
      program_verify <= 1'b0;
    end else begin
      erase_allowed  <= erase_hit & ~error_flag_reg; // see R9
      error_protect  <= error_flag_reg; // see R3
      erase_active   <= erase_go_reg;
      program_active <= prog_go_reg;
      erase_verify   <= erase_vfy_reg;
      program_verify <= prog_vfy_reg;
    end
  end
endmodule : fesc_top

// File: verification/fesc_board.sv
/*
  Board model: drives the write-protect and mode pins at the levels the bench asks.
  Assumes the bench changes its requests only between bus operations.
*/
`timescale 1ns/1ps
module fesc_board (
  input  wire logic core_clk,
  input  wire logic wp_cmd,
  input  wire logic up_cmd,
  input  wire logic lo_cmd,
  output logic      write_protect_pin,
  output logic      upper_mode_pin,
  output logic      lower_mode_pin
);
  // Pins move a little after an edge, as board logic is unrelated to the core
  // One process owns the pins, so each has a single driver
  initial begin
    {write_protect_pin, upper_mode_pin, lower_mode_pin} = 3'h0;
    forever begin
      @(posedge core_clk);
      write_protect_pin <= #3 wp_cmd;
      upper_mode_pin    <= #3 up_cmd;
      lower_mode_pin    <= #3 lo_cmd;
    end
  end
endmodule : fesc_board

// File: verification/fesc_top_monitor.sv
/*
  Checker for fesc_top: bus answer timing, read masks, error flag, modes.
  Assumes it is bound to fesc_top and that one clock drives everything.
*/
`timescale 1ns/1ps
module fesc_top_monitor (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        bus_req,
  input wire logic        bus_wr,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  bus_rdata,
  input wire logic        bus_ack,
  input wire logic        bus_sel,
  input wire logic        flash_error,
  input wire logic        erase_allowed,
  input wire logic        error_protect,
  input wire logic        boot_mode,
  input wire logic        user_program_mode
);
  // One domain, so clock and reset are given once
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_ack_after_req: assert property (bus_ack |-> $past(bus_req, 2))
    else $error("answer without request two cycles before");
  a_ack_one_cycle: assert property (bus_ack |=> !bus_ack)
    else $error("answer longer than one cycle");
  a_sel_in_window: assert property (bus_sel |-> bus_ack && $past(bus_addr, 2) inside {[16'hff80:16'hff83]})
    else $error("select outside flash register window");
  a_write_reads_zero: assert property (bus_ack && $past(bus_wr, 2) |-> bus_rdata == 8'h00)
    else $error("write answered with data");
  a_setup_reserved_zero: assert property (bus_sel && $past(bus_addr, 2) == fesc_pkg::ADDR_SETUP_ERROR
    |-> bus_rdata[6:2] == 5'h00)
    else $error("reserved setup bits not zero");
  a_monitor_reserved_zero: assert property (bus_ack && $past(bus_addr, 2) == fesc_pkg::ADDR_MODE_MON
    |-> bus_rdata[7:2] == 6'h00)
    else $error("reserved monitor bits not zero");
  a_error_sets_flag: assert property (flash_error |-> ##[1:3] error_protect)
    else $error("error did not set protection");
  a_error_stays_set: assert property (error_protect |=> error_protect)
    else $error("error protection cleared without reset");
  a_error_blocks_erase: assert property (error_protect |=> !erase_allowed)
    else $error("erase allowed under error protection");
  a_mode_exclusive: assert property (!(boot_mode && user_program_mode))
    else $error("boot and user mode both set");
endmodule : fesc_top_monitor

bind fesc_top fesc_top_monitor fesc_top_monitor_i (
  .core_clk(core_clk), .rst(rst), .bus_req(bus_req), .bus_wr(bus_wr), .bus_addr(bus_addr),
  .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_sel(bus_sel), .flash_error(flash_error),
  .erase_allowed(erase_allowed), .error_protect(error_protect), .boot_mode(boot_mode),
  .user_program_mode(user_program_mode)
);

// File: verification/fesc_top_test.sv
/*
  Self-checking bench for fesc_top: registers, permits, block map, errors, modes.
  Assumes fesc_board drives the pins and fesc_top_monitor is bound to the design.
*/
`timescale 1ns/1ps
module fesc_top_test;
  logic        core_clk, rst, bus_req, bus_wr, bus_ack, bus_sel, standby, flash_error;
  logic [15:0] bus_addr, erase_addr, a;
  logic [7:0]  bus_wdata, bus_rdata;
  logic        write_protect_pin, upper_mode_pin, lower_mode_pin, erase_allowed, error_protect;
  logic        boot_mode, user_program_mode, erase_active, program_active, erase_verify, program_verify;
  logic        wp_cmd, up_cmd, lo_cmd, map_en;
  logic [8:0]  exp_q[$];
  logic [8:0]  exp_v;
  int          bad_count, compares, seed, b;

  fesc_top fesc_top_i (.core_clk(core_clk), .rst(rst), .bus_req(bus_req), .bus_wr(bus_wr), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_sel(bus_sel),
    .write_protect_pin(write_protect_pin), .upper_mode_pin(upper_mode_pin), .lower_mode_pin(lower_mode_pin),
    .standby(standby), .flash_error(flash_error), .erase_addr(erase_addr), .erase_allowed(erase_allowed),
    .error_protect(error_protect), .boot_mode(boot_mode), .user_program_mode(user_program_mode),
    .erase_active(erase_active), .program_active(program_active), .erase_verify(erase_verify),
    .program_verify(program_verify));
  fesc_board fesc_board_i (.core_clk(core_clk), .wp_cmd(wp_cmd), .up_cmd(up_cmd), .lo_cmd(lo_cmd),
    .write_protect_pin(write_protect_pin), .upper_mode_pin(upper_mode_pin), .lower_mode_pin(lower_mode_pin));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [8:0] exp, input logic [8:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk

  // Flags are looked at off the edge so the edge's updates have landed
  task automatic chk_flag(input logic exp, input logic got);
    #1;
    chk({8'h00, exp}, {8'h00, got});
  endtask : chk_flag

  // One byte access; the note holds {select, read data}, writes answer zero
  task automatic acc(input logic wr, input logic [15:0] ad, input logic [7:0] wd, input logic [7:0] rd);
    @(posedge core_clk);
    bus_req   <= 1'b1;
    bus_wr    <= wr;
    bus_addr  <= ad;
    bus_wdata <= wd;
    exp_q.push_back({map_en && ad >= fesc_pkg::ADDR_FLASH_LO && ad <= fesc_pkg::ADDR_FLASH_HI, wr ? 8'h00 : rd});
    @(posedge core_clk);
    bus_req <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : acc

  // Pins pass a synchroniser, so allow it to settle
  task automatic pins(input logic w, input logic u, input logic l);
    wp_cmd <= w;
    up_cmd <= u;
    lo_cmd <= l;
    repeat (8) @(posedge core_clk);
  endtask : pins

  task automatic do_reset();
    rst <= 1'b1;
    map_en = 1'b0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    repeat (8) @(posedge core_clk);
    acc(1, fesc_pkg::ADDR_MAP_CTRL, 8'hff, 0);
    map_en = 1'b1;
  endtask : do_reset

  task automatic test_done();
    // A note never answered means a lost bus answer
    if (exp_q.size() != 0) bad_count++;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // Each answer takes the oldest note
  always @(posedge core_clk) begin
    if (bus_ack === 1'b1) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1ff;
      chk(exp_v, {bus_sel, bus_rdata});
    end
  end

  // Whole run is well under this span
  initial begin
    #(25 * 20000);
    bad_count++;
    test_done();
  end

  initial begin
    seed = 52245;
    {rst, bus_req, bus_wr, standby, flash_error} = 5'h10;
    {bus_addr, erase_addr, bus_wdata} = '0;
    {wp_cmd, up_cmd, lo_cmd, map_en} = 4'hc;
    {bad_count, compares} = '0;
    do_reset();
    acc(0, fesc_pkg::ADDR_MAP_CTRL, 0, 8'h08);
    acc(0, fesc_pkg::ADDR_MODE_MON, 0, 8'h02);
    acc(0, fesc_pkg::ADDR_SETUP_ERROR, 0, 8'h00);
    chk_flag(1'b1, user_program_mode);
    $display("reset and mode test done");
    acc(1, fesc_pkg::ADDR_SETUP_ERROR, 8'h02, 0);
    acc(1, fesc_pkg::ADDR_BLOCK_SEL, 8'h01, 0);
    acc(0, fesc_pkg::ADDR_SETUP_ERROR, 0, 8'h00);
    acc(1, fesc_pkg::ADDR_PRIMARY, 8'h40, 0);
    acc(0, fesc_pkg::ADDR_PRIMARY, 0, 8'hc0);
    acc(1, fesc_pkg::ADDR_SETUP_ERROR, 8'hfe, 0);
    acc(0, fesc_pkg::ADDR_SETUP_ERROR, 0, 8'h02);
    acc(1, fesc_pkg::ADDR_PRIMARY, 8'h42, 0);
    acc(0, fesc_pkg::ADDR_PRIMARY, 0, 8'hc2);
    chk_flag(1'b1, erase_active);
    acc(1, fesc_pkg::ADDR_PRIMARY, 8'h41, 0);
    acc(0, fesc_pkg::ADDR_PRIMARY, 0, 8'hc0);
    chk_flag(1'b0, program_active);
    acc(1, fesc_pkg::ADDR_PRIMARY, 8'h48, 0);
    chk_flag(1'b1, erase_verify);
    acc(1, fesc_pkg::ADDR_PRIMARY, 8'h44, 0);
    chk_flag(1'b1, program_verify);
    chk_flag(1'b0, erase_verify);
    $display("setup and go test done");
    acc(1, fesc_pkg::ADDR_BLOCK_SEL, 8'hff, 0);
    acc(0, fesc_pkg::ADDR_BLOCK_SEL, 0, 8'h7f);
    for (b = 0; b < fesc_pkg::NUM_BLOCKS; b++) begin
      acc(1, fesc_pkg::ADDR_BLOCK_SEL, 8'h01 << b, 0);
      a = fesc_pkg::BLOCK_START[b] + (16'($random(seed)) & 16'h03ff);
      erase_addr <= a;
      repeat (3) @(posedge core_clk);
      chk_flag(1'b1, erase_allowed);
      erase_addr <= fesc_pkg::BLOCK_END[b] + 16'h0001;
      repeat (3) @(posedge core_clk);
      chk_flag(1'b0, erase_allowed);
    end
    $display("block map test done");
    acc(1, fesc_pkg::ADDR_MAP_CTRL, 8'h00, 0);
    map_en = 1'b0;
    acc(1, fesc_pkg::ADDR_BLOCK_SEL, 8'h00, 0);
    acc(0, fesc_pkg::ADDR_BLOCK_SEL, 0, 8'h00);
    acc(1, fesc_pkg::ADDR_MAP_CTRL, 8'h08, 0);
    map_en = 1'b1;
    acc(0, fesc_pkg::ADDR_BLOCK_SEL, 0, 8'h40);
    @(posedge core_clk);
    standby <= 1'b1;
    @(posedge core_clk);
    standby <= 1'b0;
    acc(0, fesc_pkg::ADDR_SETUP_ERROR, 0, 8'h00);
    acc(0, fesc_pkg::ADDR_BLOCK_SEL, 0, 8'h00);
    acc(1, fesc_pkg::ADDR_PRIMARY, 8'h40, 0);
    acc(1, fesc_pkg::ADDR_BLOCK_SEL, 8'h04, 0);
    pins(1'b0, 1'b1, 1'b0);
    acc(0, fesc_pkg::ADDR_BLOCK_SEL, 0, 8'h00);
    $display("standby and protect test done");
    pins(1'b1, 1'b1, 1'b0);
    acc(1, fesc_pkg::ADDR_PRIMARY, 8'h40, 0);
    acc(1, fesc_pkg::ADDR_BLOCK_SEL, 8'h01, 0);
    erase_addr <= 16'h0000;
    repeat (3) @(posedge core_clk);
    chk_flag(1'b1, erase_allowed);
    @(posedge core_clk);
    flash_error <= 1'b1;
    @(posedge core_clk);
    flash_error <= 1'b0;
    acc(1, fesc_pkg::ADDR_SETUP_ERROR, 8'h01, 0);
    acc(0, fesc_pkg::ADDR_SETUP_ERROR, 0, 8'h80);
    chk_flag(1'b1, error_protect);
    chk_flag(1'b0, erase_allowed);
    wp_cmd <= 1'b1;
    up_cmd <= 1'b0;
    do_reset();
    acc(0, fesc_pkg::ADDR_SETUP_ERROR, 0, 8'h00);
    chk_flag(1'b1, boot_mode);
    $display("error and boot test done");
    test_done();
  end
endmodule : fesc_top_test
